// ===== verilog/xtc_core.v
// Purpose: Cross trigger coordination of one emulator/analyzer unit.
// Assumes: One clock; bus pins already synchronous; APB slave, zero wait.
// Notes:   Shared lines are wired-OR: output enable high asserts trigger and execute, pulls ready low.
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/1ps
`include "xtc_map.vh"
module xtc_core (
  // Clock and reset
  input  wire        mclk,
  input  wire        rst_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Coordination bus, active high level on the wire
  input  wire        bus_trigger_in,
  output reg         bus_trigger_oe,
  input  wire        bus_execute_in,
  output reg         bus_execute_oe,
  input  wire        bus_ready_in,
  output reg         bus_ready_oe,
  // Connector trigger
  input  wire        con_trigger_in,
  output reg         con_trigger_out,
  output reg         con_trigger_oe,
  // Analyzers
  input  wire        ana_trigger,
  input  wire        xana_trigger,
  input  wire        ana_done,
  output reg         ana_arm,
  output reg         xana_arm,
  output reg         ana_start,
  // Emulator status
  output reg         emu_break,
  output reg         emu_wait
);
  // ****************************************
  // Registers
  // ****************************************
  reg  [2:0]  ctrl;
  reg  [15:0] route;
  reg  [1:0]  run_state;
  reg  [1:0]  cause;
  reg  [1:0]  trace_state;
  reg         pend_bus;
  reg         pend_con;
  reg         tgout_act;
  reg  [1:0]  exec_ph;
  reg  [3:0]  exec_cnt;
  reg         exec_pulse;
  reg         run_req;
  wire        con_rise;
  wire        exec_rise;
  wire [1:0]  line;
  wire        wr;
  wire        rd;
  wire [31:0] cmd;
  wire        en_bus;
  wire        en_con;

  localparam EX_IDLE = 2'h0;
  localparam EX_OFF  = 2'h1;
  localparam EX_ARM  = 2'h2;
  localparam EX_ON   = 2'h3;

  function sel2;
    input [1:0] r;
    input [1:0] l;
    begin
      sel2 = |(r & l);
    end
  endfunction

  assign wr  = psel & penable & pwrite;
  assign rd  = psel & ~pwrite;
  assign cmd = (wr && paddr == `XTC_REG_CMD) ? pwdata : 32'h0000_0000;
  assign en_bus = wr && paddr == `XTC_REG_CTRL && pwdata[`XTC_CTRL_BRK_BUS]
                  && !ctrl[`XTC_CTRL_BRK_BUS];
  assign en_con = wr && paddr == `XTC_REG_CTRL && pwdata[`XTC_CTRL_BRK_CON]
                  && !ctrl[`XTC_CTRL_BRK_CON];

  xtc_edge u_con (
    .mclk  (mclk),
    .rst_n (rst_n),
    .level (con_trigger_in),
    .rise  (con_rise)
  );

  xtc_edge u_exe (
    .mclk  (mclk),
    .rst_n (rst_n),
    .level (bus_execute_in),
    .rise  (exec_rise)
  );

  // ****************************************
  // Internal trigger lines a and b
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_line
      assign line[g] = (route[`XTC_RT_TGOUT + g] & tgout_act)
                     | (route[`XTC_RT_XTGOUT + g] & xana_trigger)
                     | (route[`XTC_RT_CON_IN + g] & con_trigger_in)
                     | (route[`XTC_RT_BUS_IN + g] & bus_trigger_in);
    end
  endgenerate

  // ****************************************
  // APB slave and control
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= 3'h0;
      route   <= 16'h0000;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `XTC_REG_STATUS || paddr[1:0] != 2'h0);
      if (wr && paddr == `XTC_REG_CTRL) begin
        ctrl <= pwdata[2:0];
      end
      if (wr && paddr == `XTC_REG_ROUTE) begin
        route <= pwdata[15:0];
      end
      prdata <= 32'h0000_0000;
      if (rd && !penable) begin
        case (paddr)
          `XTC_REG_CTRL:   prdata <= {29'h0, ctrl};
          `XTC_REG_ROUTE:  prdata <= {16'h0, route};
          `XTC_REG_BREAK:  prdata <= {28'h0, pend_con, pend_bus, cause};
          `XTC_REG_STATUS: prdata <= {24'h0, tgout_act, exec_ph, trace_state,
                                      run_state == `XTC_ST_WAIT, run_state};
          default:         prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************
  // Break requests and run state
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_bus  <= 1'b0;
      pend_con  <= 1'b0;
      run_state <= `XTC_ST_RUN;
      cause     <= `XTC_CAUSE_NONE;
      run_req   <= 1'b0;
    end else begin
      if (en_bus) begin
        pend_bus <= bus_trigger_in & ~bus_trigger_oe;
      end else if (ctrl[`XTC_CTRL_BRK_BUS] && bus_trigger_in) begin
        pend_bus <= 1'b1;
      end else if (run_state == `XTC_ST_MON) begin
        pend_bus <= 1'b0;
      end
      if (en_con) begin
        pend_con <= 1'b0;
      end else if (ctrl[`XTC_CTRL_BRK_CON] && con_rise) begin
        pend_con <= 1'b1;
      end else if (run_state == `XTC_ST_MON) begin
        pend_con <= 1'b0;
      end
      if (cmd[`XTC_CMD_RUN]) begin
        run_req <= 1'b1;
      end else if (run_state != `XTC_ST_MON) begin
        run_req <= 1'b0;
      end
      case (run_state)
        `XTC_ST_RUN: begin
          if (pend_bus) begin
            run_state <= `XTC_ST_MON;
            cause     <= `XTC_CAUSE_BUS;
          end else if (pend_con) begin
            run_state <= `XTC_ST_MON;
            cause     <= `XTC_CAUSE_CON;
          end else if (cmd[`XTC_CMD_BREAK]) begin
            run_state <= `XTC_ST_MON;
            cause     <= `XTC_CAUSE_USER;
          end else if (ctrl[`XTC_CTRL_PART] && (!bus_ready_in || exec_rise)) begin
            run_state <= `XTC_ST_WAIT;
          end
        end
        `XTC_ST_MON: begin
          if (run_req) begin
            run_state <= ctrl[`XTC_CTRL_PART] ? `XTC_ST_WAIT : `XTC_ST_RUN;
          end
        end
        `XTC_ST_WAIT: begin
          if (!ctrl[`XTC_CTRL_PART] || (bus_ready_in && exec_ph == EX_IDLE)) begin
            run_state <= `XTC_ST_RUN;
          end
        end
        default: run_state <= `XTC_ST_RUN;
      endcase
    end
  end

  // ****************************************
  // Execute sequence and trace state
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      exec_ph     <= EX_IDLE;
      exec_cnt    <= 4'h0;
      exec_pulse  <= 1'b0;
      trace_state <= `XTC_TR_IDLE;
      tgout_act   <= 1'b0;
    end else begin
      exec_pulse <= cmd[`XTC_CMD_EXEC] & ctrl[`XTC_CTRL_PART];
      case (exec_ph)
        EX_IDLE: begin
          if (exec_rise && ctrl[`XTC_CTRL_PART]) begin
            exec_ph  <= EX_OFF;
            exec_cnt <= `XTC_EXEC_GAP;
          end
        end
        EX_OFF: begin
          exec_cnt <= exec_cnt - 4'h1;
          if (exec_cnt == 4'h1) begin
            exec_ph <= EX_ARM;
          end
        end
        EX_ARM: begin
          exec_ph  <= EX_ON;
          exec_cnt <= `XTC_EXEC_GAP;
        end
        EX_ON: begin
          exec_cnt <= exec_cnt - 4'h1;
          if (exec_cnt == 4'h1) begin
            exec_ph <= EX_IDLE;
          end
        end
        default: exec_ph <= EX_IDLE;
      endcase
      if (cmd[`XTC_CMD_THALT]) begin
        trace_state <= `XTC_TR_HALT;
      end else if (cmd[`XTC_CMD_TSTART] || exec_ph == EX_ARM) begin
        trace_state <= `XTC_TR_RUN;
      end else if (trace_state == `XTC_TR_RUN && ana_done) begin
        trace_state <= `XTC_TR_DONE;
      end
      if (ana_trigger && trace_state == `XTC_TR_RUN) begin
        tgout_act <= 1'b1;
      end else if (cmd[`XTC_CMD_TSTART] || cmd[`XTC_CMD_ACK]) begin
        tgout_act <= 1'b0;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_trigger_oe  <= 1'b0;
      bus_execute_oe  <= 1'b0;
      bus_ready_oe    <= 1'b0;
      con_trigger_out <= 1'b0;
      con_trigger_oe  <= 1'b0;
      ana_arm         <= 1'b0;
      xana_arm        <= 1'b0;
      ana_start       <= 1'b0;
      emu_break       <= 1'b0;
      emu_wait        <= 1'b0;
    end else begin
      // Only three shared lines are driven.
      bus_trigger_oe  <= sel2(route[`XTC_RT_BUS_OUT +: 2], line)
                         && exec_ph != EX_OFF && exec_ph != EX_ARM;
      bus_execute_oe  <= exec_pulse;
      bus_ready_oe    <= ctrl[`XTC_CTRL_PART] &&
                         (run_state == `XTC_ST_MON || exec_ph != EX_IDLE);
      con_trigger_out <= sel2(route[`XTC_RT_CON_OUT +: 2], line);
      con_trigger_oe  <= |route[`XTC_RT_CON_OUT +: 2];
      ana_arm         <= sel2(route[`XTC_RT_ARM +: 2], line);
      xana_arm        <= sel2(route[`XTC_RT_XARM +: 2], line);
      ana_start       <= exec_ph == EX_ARM;
      emu_break       <= run_state == `XTC_ST_MON;
      emu_wait        <= run_state == `XTC_ST_WAIT;
    end
  end
endmodule // xtc_core

// ===== verilog/xtc_map.vh
// Purpose: Constants for the cross trigger coordination block.
// Assumes: APB with 32-bit data, word aligned registers.
// Notes:   Overview and register map follow.
//
// Overview of operation
// - Bus carries only trigger, execute, ready.
// - Execute pulse starts every enabled unit.
// - Peer break puts unit into wait.
// - Own monitor break pulls ready false.
// - Enabling connector break clears its pending.
// - Enable breaks at once only on bus trigger.
// - Bus trigger break reports bus cause.
// - Connector trigger break records connector cause.
// - Routed internal line drives connector output.
// - Internal lines route arm, triggers, connector, bus.
// - Wait state shows a distinct wait flag.
// - Trace status: complete, halted or running.
// - Stopped units resume when ready returns.
// - Execute: drivers off, start analyzers, drivers on.
// - Trigger output drops on restart or answer.
`ifndef XTC_MAP_VH
`define XTC_MAP_VH
// ****************************************
// Register offsets
// ****************************************
`define XTC_REG_CTRL   12'h000
`define XTC_REG_ROUTE  12'h004
`define XTC_REG_BREAK  12'h008
`define XTC_REG_CMD    12'h00C
`define XTC_REG_STATUS 12'h010
// ****************************************
// Control fields
// ****************************************
`define XTC_CTRL_PART   0
`define XTC_CTRL_BRK_BUS 1
`define XTC_CTRL_BRK_CON 2
// ****************************************
// Route fields, bit a then bit b
// ****************************************
`define XTC_RT_TGOUT   0
`define XTC_RT_XTGOUT  2
`define XTC_RT_ARM     4
`define XTC_RT_XARM    6
`define XTC_RT_CON_IN  8
`define XTC_RT_CON_OUT 10
`define XTC_RT_BUS_IN  12
`define XTC_RT_BUS_OUT 14
// ****************************************
// Command bits, write one to act
// ****************************************
`define XTC_CMD_EXEC   0
`define XTC_CMD_BREAK  1
`define XTC_CMD_RUN    2
`define XTC_CMD_TSTART 3
`define XTC_CMD_THALT  4
`define XTC_CMD_ACK    5
// ****************************************
// Break cause codes
// ****************************************
`define XTC_CAUSE_NONE 2'h0
`define XTC_CAUSE_USER 2'h1
`define XTC_CAUSE_BUS  2'h2
`define XTC_CAUSE_CON  2'h3
// ****************************************
// Run states and trace states
// ****************************************
`define XTC_ST_RUN     2'h0
`define XTC_ST_MON     2'h1
`define XTC_ST_WAIT    2'h2
`define XTC_TR_IDLE    2'h0
`define XTC_TR_RUN     2'h1
`define XTC_TR_DONE    2'h2
`define XTC_TR_HALT    2'h3
// ****************************************
// Execute sequence lengths in cycles
// ****************************************
`define XTC_EXEC_GAP   4'h2
`endif

// ===== verilog/xtc_edge.v
// Purpose: Rising edge detector on a synchronous input.
// Assumes: Input already synchronous to mclk.
// Notes:   Pulse lasts one cycle.
`timescale 1ns/1ps
module xtc_edge (
  // Clock and reset
  input  wire mclk,
  input  wire rst_n,
  // Level in, pulse out
  input  wire level,
  output wire rise
);
  reg prev;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
endmodule // xtc_edge

// ===== dv/xtc_core_chk.sv
// Purpose: Port assertions for the coordination block.
// Assumes: One clock, reset asynchronous and active low.
// Notes:   Bound to every xtc_core instance.
`timescale 1ns/1ps
module xtc_chk (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Watched ports
  input wire bus_ready_in,
  input wire bus_trigger_oe,
  input wire bus_execute_oe,
  input wire bus_ready_oe,
  input wire ana_start,
  input wire emu_break,
  input wire emu_wait
);
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_START_PULSE: assert property (ana_start |=> !ana_start)
    else $error("Start pulse longer than one cycle.");
  AST_EXEC_PULSE: assert property (bus_execute_oe |=> !bus_execute_oe)
    else $error("Execute drive longer than one cycle.");
  AST_START_NO_DRIVE: assert property (ana_start |-> !bus_trigger_oe)
    else $error("Trigger driven while analyzers start.");
  AST_START_HOLD_READY: assert property (ana_start |-> bus_ready_oe)
    else $error("Ready not held during execute sequence.");
  AST_BREAK_READY: assert property ($rose(emu_break) |-> ##[0:2] bus_ready_oe)
    else $error("Break did not pull ready false.");
  AST_BREAK_HOLD: assert property (emu_break [*3] |-> bus_ready_oe)
    else $error("Ready released while in monitor.");
  AST_WAIT_EXCL: assert property (emu_wait |-> !emu_break)
    else $error("Wait and monitor shown together.");
  AST_RESUME: assert property (emu_wait && bus_ready_in |-> ##[1:4] !emu_wait)
    else $error("Unit stays in wait with ready true.");
  AST_NO_EARLY_RESUME: assert property ($fell(emu_wait) && !emu_break |->
    $past(bus_ready_in) || $past(bus_ready_in, 2))
    else $error("Unit left wait without ready.");
endmodule // xtc_chk
bind xtc_core xtc_chk xtc_chk_inst (.mclk(mclk), .rst_n(rst_n), .bus_ready_in(bus_ready_in),
  .bus_trigger_oe(bus_trigger_oe), .bus_execute_oe(bus_execute_oe),
  .bus_ready_oe(bus_ready_oe), .ana_start(ana_start), .emu_break(emu_break),
  .emu_wait(emu_wait));

// ===== dv/xtc_peer.sv
// Purpose: Peer units and external trigger source on the far side.
// Assumes: Bench sets the peer controls at rising edges.
// Notes:   Lines are resolved here and fed back to the block.
`timescale 1ns/1ps
module xtc_peer (
  // Drives of the unit under test
  input  wire bus_trigger_oe,
  input  wire bus_execute_oe,
  input  wire bus_ready_oe,
  input  wire con_trigger_out,
  input  wire con_trigger_oe,
  // Peer and external controls
  input  wire peer_trigger,
  input  wire peer_execute,
  input  wire peer_hold_ready,
  input  wire ext_level,
  // Resolved levels
  output wire bus_trigger_in,
  output wire bus_execute_in,
  output wire bus_ready_in,
  output wire con_trigger_in
);
  // ****************************************
  // Line resolution
  // ****************************************
  assign bus_trigger_in = bus_trigger_oe | peer_trigger;
  assign bus_execute_in = bus_execute_oe | peer_execute;
  assign bus_ready_in   = ~(bus_ready_oe | peer_hold_ready);
  assign con_trigger_in = con_trigger_oe ? con_trigger_out : ext_level;
endmodule // xtc_peer

// ===== dv/xtc_core_tb.sv
// Purpose: Self checking bench for the coordination block.
// Assumes: Zero wait APB slave, 25 MHz clock.
// Notes:   Peers and the external source live in xtc_peer.
`timescale 1ns/1ps
`include "xtc_map.vh"
`define CHK(g, e) begin tests_run = tests_run + 1; if ((g) !== (e)) begin \
  err_count = err_count + 1; $display("Error t=%0t got %0h exp %0h", $time, g, e); end end
module xtc_core_tb;
  // ****************************************
  // Signals
  // ****************************************
  reg         mclk, rst_n, psel, penable, pwrite, ana_trigger, xana_trigger, ana_done;
  reg         peer_trigger, peer_execute, peer_hold_ready, ext_level, er;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  wire [31:0] prdata;
  wire        pready, pslverr, bus_trigger_in, bus_trigger_oe, bus_execute_in, bus_execute_oe;
  wire        bus_ready_in, bus_ready_oe, con_trigger_in, con_trigger_out, con_trigger_oe;
  wire        ana_arm, xana_arm, ana_start, emu_break, emu_wait;
  integer     err_count, tests_run, i, n;
  reg  [23:0] c;
  xtc_core xtc_core_inst (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bus_trigger_in(bus_trigger_in), .bus_trigger_oe(bus_trigger_oe),
    .bus_execute_in(bus_execute_in), .bus_execute_oe(bus_execute_oe),
    .bus_ready_in(bus_ready_in), .bus_ready_oe(bus_ready_oe), .con_trigger_in(con_trigger_in),
    .con_trigger_out(con_trigger_out), .con_trigger_oe(con_trigger_oe),
    .ana_trigger(ana_trigger), .xana_trigger(xana_trigger), .ana_done(ana_done),
    .ana_arm(ana_arm), .xana_arm(xana_arm), .ana_start(ana_start), .emu_break(emu_break),
    .emu_wait(emu_wait));
  xtc_peer xtc_peer_inst (.bus_trigger_oe(bus_trigger_oe), .bus_execute_oe(bus_execute_oe),
    .bus_ready_oe(bus_ready_oe), .con_trigger_out(con_trigger_out),
    .con_trigger_oe(con_trigger_oe), .peer_trigger(peer_trigger), .peer_execute(peer_execute),
    .peer_hold_ready(peer_hold_ready), .ext_level(ext_level), .bus_trigger_in(bus_trigger_in),
    .bus_execute_in(bus_execute_in), .bus_ready_in(bus_ready_in),
    .con_trigger_in(con_trigger_in));
  // ****************************************
  // Tasks
  // ****************************************
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    begin
      @(posedge mclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      n = 0;
      @(posedge mclk);
      while (pready !== 1'h1 && n < 20) begin
        @(posedge mclk);
        n = n + 1;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      if (n >= 20) err_count = err_count + 1;
    end
  endtask
  function automatic logic pick(input integer k);
    case (k)
      0: pick = emu_break;
      1: pick = emu_wait;
      2: pick = ana_start;
      3: pick = con_trigger_oe & con_trigger_out;
      4: pick = ana_arm;
      5: pick = xana_arm;
      6: pick = bus_trigger_oe;
      default: pick = bus_ready_oe;
    endcase
  endfunction
  // Routing case k: stimulus in [23:20], observed output in [19:16], route word below.
  function automatic [23:0] cfg(input integer k);
    case (k)
      0: cfg = {4'h0, 4'h4, 16'h0110};
      1: cfg = {4'h1, 4'h5, 16'h2080};
      2: cfg = {4'h2, 4'h3, 16'h0404};
      3: cfg = {4'h3, 4'h3, 16'h0401};
      default: cfg = {4'h3, 4'h6, 16'h8002};
    endcase
  endfunction
  task await(input integer k, input logic v);
    begin
      n = 0;
      @(negedge mclk);
      while (pick(k) !== v && n < 40) begin
        @(negedge mclk);
        n = n + 1;
      end
      `CHK(pick(k), v)
    end
  endtask
  task set_stim(input integer k, input logic v);
    case (k)
      0: ext_level <= v;
      1: peer_trigger <= v;
      2: xana_trigger <= v;
      default: ana_trigger <= v;
    endcase
  endtask
  task give_verdict;
    begin
      $display("Counts: %0d checks, %0d mismatches", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #(40 * 20000);
    err_count = err_count + 1;
    give_verdict;
  end
  initial begin
    {err_count, tests_run} = 0;
    {rst_n, psel, penable, pwrite, ana_trigger, xana_trigger, ana_done} = 0;
    {peer_trigger, peer_execute, peer_hold_ready, ext_level, paddr, pwdata} = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'h1;
    apb(1'h0, `XTC_REG_STATUS, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h0, 12'h014, 32'h0);
    `CHK(er, 1'h1)
    $display("Test reset done.");
    apb(1'h1, `XTC_REG_CTRL, 32'h5);
    ext_level <= 1'h1;
    await(0, 1'h1);
    await(7, 1'h1);
    apb(1'h0, `XTC_REG_BREAK, 32'h0);
    `CHK(rd[1:0], `XTC_CAUSE_CON)
    ext_level <= 1'h0;
    apb(1'h1, `XTC_REG_CTRL, 32'h1);
    apb(1'h1, `XTC_REG_CMD, 32'h4);
    await(0, 1'h0);
    @(posedge mclk);
    peer_trigger <= 1'h1;
    apb(1'h1, `XTC_REG_CTRL, 32'h3);
    await(0, 1'h1);
    apb(1'h0, `XTC_REG_BREAK, 32'h0);
    `CHK(rd[1:0], `XTC_CAUSE_BUS)
    peer_trigger <= 1'h0;
    apb(1'h1, `XTC_REG_CTRL, 32'h1);
    apb(1'h1, `XTC_REG_CMD, 32'h4);
    await(0, 1'h0);
    $display("Test break causes done.");
    @(posedge mclk);
    peer_trigger <= 1'h1;
    apb(1'h0, `XTC_REG_BREAK, 32'h0);
    peer_trigger <= 1'h0;
    apb(1'h1, `XTC_REG_CTRL, 32'h3);
    apb(1'h0, `XTC_REG_BREAK, 32'h0);
    `CHK(rd[2], 1'h0)
    await(0, 1'h0);
    apb(1'h1, `XTC_REG_CTRL, 32'h1);
    $display("Test stale break done.");
    peer_hold_ready <= 1'h1;
    await(1, 1'h1);
    apb(1'h0, `XTC_REG_STATUS, 32'h0);
    `CHK(rd[2:0], {1'h1, `XTC_ST_WAIT})
    peer_hold_ready <= 1'h0;
    await(1, 1'h0);
    $display("Test wait done.");
    apb(1'h1, `XTC_REG_CMD, 32'h2);
    await(0, 1'h1);
    apb(1'h0, `XTC_REG_BREAK, 32'h0);
    `CHK(rd[1:0], `XTC_CAUSE_USER)
    apb(1'h1, `XTC_REG_CMD, 32'h4);
    await(0, 1'h0);
    $display("Test user break done.");
    apb(1'h1, `XTC_REG_ROUTE, 32'h0000_4100);
    ext_level <= 1'h1;
    for (i = 0; i < 2; i = i + 1) begin
      if (i == 0)
        apb(1'h1, `XTC_REG_CMD, 32'h1);
      else begin
        @(posedge mclk);
        peer_execute <= 1'h1;
      end
      await(2, 1'h1);
      `CHK(bus_trigger_oe, 1'h0)
      @(posedge mclk);
      peer_execute <= 1'h0;
      await(7, 1'h0);
      await(1, 1'h0);
      `CHK(bus_trigger_oe, 1'h1)
    end
    $display("Test execute done.");
    apb(1'h1, `XTC_REG_CMD, 32'h8);
    ext_level <= 1'h0;
    apb(1'h0, `XTC_REG_STATUS, 32'h0);
    `CHK(rd[4:3], `XTC_TR_RUN)
    ana_done <= 1'h1;
    apb(1'h0, `XTC_REG_STATUS, 32'h0);
    `CHK(rd[4:3], `XTC_TR_DONE)
    ana_done <= 1'h0;
    apb(1'h1, `XTC_REG_CMD, 32'h8);
    apb(1'h1, `XTC_REG_CMD, 32'h10);
    apb(1'h0, `XTC_REG_STATUS, 32'h0);
    `CHK(rd[4:3], `XTC_TR_HALT)
    $display("Test trace status done.");
    apb(1'h1, `XTC_REG_CMD, 32'h8);
    for (i = 0; i < 5; i = i + 1) begin
      c = cfg(i);
      apb(1'h1, `XTC_REG_ROUTE, {16'h0, c[15:0]});
      apb(1'h0, `XTC_REG_ROUTE, 32'h0);
      `CHK(rd, {16'h0, c[15:0]})
      set_stim(c[23:20], 1'h1);
      await(c[19:16], 1'h1);
      @(posedge mclk);
      set_stim(c[23:20], 1'h0);
      apb(1'h1, `XTC_REG_CMD, 32'h20);
    end
    apb(1'h0, `XTC_REG_STATUS, 32'h0);
    `CHK(rd[7], 1'h0)
    $display("Test routing done.");
    give_verdict;
  end
endmodule // xtc_core_tb
